// ---- test/asg_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// The pin shows the port's drive where enabled, else the outside level.
module asg_pin_model (
    // Drive from the port.
    input wire asg_pkg::asg_drive_type drive_in,
    // Level forced by the board.
    input wire logic [7:0] ext_in,
    // Resulting pin level.
    output logic [7:0] pin_out
);
    assign pin_out = (drive_in.oe & drive_in.out) | (~drive_in.oe & ext_in);
endmodule

`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    asg_pkg::asg_req_type req = '0;
    logic [7:0] rdata;
    logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] pin_one, pin_mix, pin_up;
    asg_pkg::asg_drive_type drv_one, drv_mix, drv_up;
    asg_pkg::asg_conv_type conv;
    logic [15:0] chan;
    logic vpos, vneg, cap, rx, sck;
    logic pwm_on = 1'b0, pwm_val = 1'b0, ser_on = 1'b0;
    logic tx = 1'b0, tx_oe = 1'b0, dt = 1'b0, dt_oe = 1'b0;
    int n_fail = 0;
    int compares = 0;
    int m_dir [3];
    int m_lat [3];
    int m_cfg;

    always #2 clk_in = ~clk_in;

    asg_ports u_asg_ports (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
        .rdata_out(rdata), .port_one_pin_in(pin_one),
        .mixed_pin_in(pin_mix), .upper_pin_in(pin_up),
        .port_one_drive_out(drv_one), .mixed_drive_out(drv_mix),
        .upper_drive_out(drv_up), .conv_cfg_out(conv),
        .analog_channel_out(chan), .vref_pos_out(vpos),
        .vref_neg_out(vneg), .third_capture_input_out(cap),
        .third_pulse_on_in(pwm_on), .third_pulse_output_in(pwm_val),
        .second_serial_on_in(ser_on), .second_serial_transmit_in(tx),
        .second_serial_transmit_oe_in(tx_oe),
        .second_serial_sync_data_in(dt),
        .second_serial_sync_data_oe_in(dt_oe),
        .second_serial_receive_out(rx),
        .second_serial_sync_clock_out(sck)
    );
    asg_pin_model u_pin_one (
        .drive_in(drv_one), .ext_in(ext[0]), .pin_out(pin_one)
    );
    asg_pin_model u_pin_mix (
        .drive_in(drv_mix), .ext_in(ext[1]), .pin_out(pin_mix)
    );
    asg_pin_model u_pin_up (
        .drive_in(drv_up), .ext_in(ext[2]), .pin_out(pin_up)
    );

    function automatic logic [3:0] pbank(input int p);
        return p == 2 ? asg_pkg::BANK_HIGH : asg_pkg::BANK_LOW;
    endfunction
    function automatic logic [7:0] pdir(input int p);
        return p == 0 ? asg_pkg::OFF_PORT_ONE_DIR :
            p == 1 ? asg_pkg::OFF_MIXED_DIR : asg_pkg::OFF_UPPER_DIR;
    endfunction
    function automatic logic [7:0] ppin(input int p);
        return p == 0 ? asg_pkg::OFF_PORT_ONE_PINS :
            p == 1 ? asg_pkg::OFF_MIXED_PINS : asg_pkg::OFF_UPPER_PINS;
    endfunction
    function automatic asg_pkg::asg_drive_type drv(input int p);
        return p == 0 ? drv_one : p == 1 ? drv_mix : drv_up;
    endfunction
    // Pins held analog by the pin configuration, per port.
    function automatic int amask(input int p);
        if ((m_cfg & 15) >= 14) begin
            return 0;
        end
        return p == 0 ? 'hFF : p == 1 ? 'h0F : 'hF0;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] b, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk_in);
        req <= {b, a, 1'b1, 1'b0, d};
        @(posedge clk_in);
        req <= '0;
    endtask
    task automatic rd(input logic [3:0] b, input logic [7:0] a,
        output logic [7:0] d);
        @(posedge clk_in);
        req <= {b, a, 1'b0, 1'b1, 8'h00};
        @(posedge clk_in);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic model_reset();
        for (int p = 0; p < 3; p++) begin
            m_dir[p] = 255;
            m_lat[p] = 0;
        end
        m_cfg = 0;
    endtask
    task automatic push(input int cw);
        m_cfg = cw & 'hEF;
        wr(asg_pkg::BANK_LOW, asg_pkg::OFF_CONV_CFG, cw[7:0]);
        for (int p = 0; p < 3; p++) begin
            wr(pbank(p), ppin(p), m_lat[p][7:0]);
            wr(pbank(p), pdir(p), m_dir[p][7:0]);
        end
    endtask
    task automatic check_all(input string t);
        logic [7:0] d;
        int oe;
        asg_pkg::asg_drive_type dv;
        repeat (3) @(posedge clk_in);
        for (int p = 0; p < 3; p++) begin
            oe = ~m_dir[p] & ~amask(p) & 255;
            dv = drv(p);
            chk(dv.oe, oe, "oe");
            chk(dv.out & oe, m_lat[p] & oe, "out");
            rd(pbank(p), ppin(p), d);
            chk(d, ((oe & m_lat[p]) | (~oe & ext[p])) & ~amask(p) & 255,
                "pins");
            rd(pbank(p), pdir(p), d);
            chk(d, m_dir[p], "dir");
        end
        rd(asg_pkg::BANK_LOW, asg_pkg::OFF_CONV_CFG, d);
        chk(d, m_cfg, "cfg");
        chk(chan, (m_cfg & 15) >= 14 ? 0 : (m_cfg & 15) == 1 ? 'hFFFC :
            'hFFFF, "chan");
        chk({vpos, vneg}, (m_cfg & 15) == 1 ? 3 : 0, "vref");
        chk(conv, ((m_cfg >> 1) & 'h70) | (m_cfg & 15), "conv");
        $display("test %s done", t);
    endtask
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        final_report();
    end

    initial begin
        logic [7:0] d;
        asg_pkg::asg_drive_type dv;
        void'($urandom(32'hDC8484CE));
        model_reset();
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        check_all("reset");
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_in);
            for (int p = 0; p < 3; p++) begin
                m_dir[p] = $urandom & 255;
                m_lat[p] = $urandom & 255;
                ext[p] <= $urandom;
            end
            push(i == 0 ? 'h11 : i == 1 ? 'h10 :
                ($urandom & 'hFF) | (i % 2 ? 'h0E : 0));
            check_all("random");
        end
        wr(asg_pkg::BANK_HIGH, asg_pkg::OFF_MIXED_PINS, 8'hFF);
        rd(asg_pkg::BANK_HIGH, asg_pkg::OFF_CONV_CFG, d);
        chk(d, 0, "unmapped");
        check_all("unmapped");
        model_reset();
        push('h0E);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_in);
            pwm_on <= 1'b1;
            pwm_val <= v[0];
            ser_on <= 1'b1;
            tx <= v[0];
            tx_oe <= 1'b1;
            dt <= v[0];
            dt_oe <= ~v[0];
            ext[1] <= v[0] ? 8'h50 : 8'h00;
            repeat (4) @(posedge clk_in);
            #1 dv = drv_mix;
            chk(dv.oe[7:4], v[0] ? 4'hA : 4'hE, "alt oe");
            chk(dv.out[7:5], {3{v[0]}}, "alt out");
            chk({cap, rx, sck}, {3{v[0]}}, "alt in");
        end
        @(posedge clk_in);
        pwm_on <= 1'b0;
        ser_on <= 1'b0;
        $display("test alternate done");
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        model_reset();
        check_all("second reset");
        final_report();
    end
endmodule

`default_nettype wire

// ---- verilog/asg_pkg.sv ----
`default_nettype none

package asg_pkg;

    // Banks that hold the port registers.
    localparam logic [3:0] BANK_LOW = 4'h5;
    localparam logic [3:0] BANK_HIGH = 4'h8;

    // Offsets inside a bank.
    localparam logic [7:0] OFF_PORT_ONE_DIR = 8'h10;
    localparam logic [7:0] OFF_PORT_ONE_PINS = 8'h11;
    localparam logic [7:0] OFF_MIXED_DIR = 8'h12;
    localparam logic [7:0] OFF_MIXED_PINS = 8'h13;
    localparam logic [7:0] OFF_CONV_CFG = 8'h15;
    localparam logic [7:0] OFF_UPPER_DIR = 8'h10;
    localparam logic [7:0] OFF_UPPER_PINS = 8'h11;

    // Reset values.
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_CONV_CFG = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Converter configuration fields.
    localparam int CFG_CLK_HI = 7;
    localparam int CFG_CLK_LO = 6;
    localparam int CFG_FORMAT = 5;
    localparam int CFG_PCFG_HI = 3;

    // Pin configuration codes.
    localparam logic [3:0] PCFG_DIGITAL_MIN = 4'hE;
    localparam logic [3:0] PCFG_EXT_REF = 4'h1;

    // Mixed port alternate function bit positions.
    localparam int MIX_REF_NEG = 2;
    localparam int MIX_REF_POS = 3;
    localparam int MIX_CAPTURE = 4;
    localparam int MIX_PULSE = 5;
    localparam int MIX_SER_RX = 6;
    localparam int MIX_SER_TX = 7;

    // Converter channels that double as reference inputs.
    localparam int CH_REF_POS = 0;
    localparam int CH_REF_NEG = 1;

    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } asg_req_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } asg_drive_type;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic result_format_select;
        logic [3:0] pcfg;
    } asg_conv_type;

endpackage

`default_nettype wire

// ---- verilog/asg_ports.sv ----
// Overview of operation
// - Direction one means input, zero drives latch.
// - Reads return pins; writes only load latch.
// - Mixed and upper ports: eight directed pins.
// - Mixed bits 3..0 map to channels 0..3.
// - Mixed bit 3 doubles as positive reference.
// - Mixed bit 2 doubles as negative reference.
// - Mixed bit 4 capture, bit 5 pulse.
// - Mixed bits 7,6 carry second serial port.
// - Reset makes mixed low nibble analog.
// - Upper bits 7..4 map to channels 15..12.
// - Upper bits 3..0 are plain digital pins.
// - Reset makes upper high nibble analog.
// - Port one bits map to channels 4..11.
// - All direction registers reset to ones.
// - Converter config bit 4 reads zero.
// - Reset makes all port one pins analog.
`timescale 1ns/1ps
`default_nettype none

module asg_ports (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register access from the core.
    input wire asg_pkg::asg_req_type req_in,
    output logic [7:0] rdata_out,
    // Port pins.
    input wire logic [7:0] port_one_pin_in,
    input wire logic [7:0] mixed_pin_in,
    input wire logic [7:0] upper_pin_in,
    output asg_pkg::asg_drive_type port_one_drive_out,
    output asg_pkg::asg_drive_type mixed_drive_out,
    output asg_pkg::asg_drive_type upper_drive_out,
    // Converter side.
    output asg_pkg::asg_conv_type conv_cfg_out,
    output logic [15:0] analog_channel_out,
    output logic vref_pos_out,
    output logic vref_neg_out,
    // Capture and pulse side.
    output logic third_capture_input_out,
    input wire logic third_pulse_on_in,
    input wire logic third_pulse_output_in,
    // Second serial port side.
    input wire logic second_serial_on_in,
    input wire logic second_serial_transmit_in,
    input wire logic second_serial_transmit_oe_in,
    input wire logic second_serial_sync_data_in,
    input wire logic second_serial_sync_data_oe_in,
    output logic second_serial_receive_out,
    output logic second_serial_sync_clock_out
);

    // Channels that the pin configuration makes analog.
    function automatic logic [15:0] analog_mask(input logic [3:0] pcfg);
        analog_mask = (pcfg >= asg_pkg::PCFG_DIGITAL_MIN) ? 16'h0000
                                                           : 16'hFFFF;
    endfunction

    // Register hit for one bank and offset.
    function automatic logic reg_hit(
        input asg_pkg::asg_req_type req,
        input logic [3:0] bank,
        input logic [7:0] off
    );
        reg_hit = (req.bank == bank) && (req.addr == off);
    endfunction

    logic [7:0] port_one_dir;
    logic [7:0] mixed_dir;
    logic [7:0] upper_dir;
    logic [7:0] port_one_latch;
    logic [7:0] mixed_latch;
    logic [7:0] upper_latch;
    logic [7:0] conv_cfg;
    logic [7:0] port_one_meta;
    logic [7:0] mixed_meta;
    logic [7:0] upper_meta;
    logic [7:0] port_one_sync;
    logic [7:0] mixed_sync;
    logic [7:0] upper_sync;
    logic [7:0] read_data;

    // Address decode.
    wire logic hit_port_one_dir;
    wire logic hit_port_one_pins;
    wire logic hit_mixed_dir;
    wire logic hit_mixed_pins;
    wire logic hit_conv_cfg;
    wire logic hit_upper_dir;
    wire logic hit_upper_pins;
    assign hit_port_one_dir = reg_hit(req_in, asg_pkg::BANK_LOW,
                                      asg_pkg::OFF_PORT_ONE_DIR);
    assign hit_port_one_pins = reg_hit(req_in, asg_pkg::BANK_LOW,
                                       asg_pkg::OFF_PORT_ONE_PINS);
    assign hit_mixed_dir = reg_hit(req_in, asg_pkg::BANK_LOW,
                                   asg_pkg::OFF_MIXED_DIR);
    assign hit_mixed_pins = reg_hit(req_in, asg_pkg::BANK_LOW,
                                    asg_pkg::OFF_MIXED_PINS);
    assign hit_conv_cfg = reg_hit(req_in, asg_pkg::BANK_LOW,
                                  asg_pkg::OFF_CONV_CFG);
    assign hit_upper_dir = reg_hit(req_in, asg_pkg::BANK_HIGH,
                                   asg_pkg::OFF_UPPER_DIR);
    assign hit_upper_pins = reg_hit(req_in, asg_pkg::BANK_HIGH,
                                    asg_pkg::OFF_UPPER_PINS);

    // Analog selection per pin.
    wire logic [15:0] chan_analog;
    wire logic ext_ref;
    wire logic [7:0] port_one_analog;
    wire logic [7:0] mixed_analog;
    wire logic [7:0] upper_analog;
    assign chan_analog = analog_mask(conv_cfg[asg_pkg::CFG_PCFG_HI:0]);
    assign ext_ref = conv_cfg[asg_pkg::CFG_PCFG_HI:0] == asg_pkg::PCFG_EXT_REF;
    assign port_one_analog = chan_analog[11:4];
    assign mixed_analog = {4'h0, chan_analog[0], chan_analog[1],
                           chan_analog[2], chan_analog[3]};
    assign upper_analog = {chan_analog[15:12], 4'h0};

    // Digital input path, gated off for analog pins.
    wire logic [7:0] port_one_read;
    wire logic [7:0] mixed_read;
    wire logic [7:0] upper_read;
    assign port_one_read = port_one_sync & ~port_one_analog;
    assign mixed_read = mixed_sync & ~mixed_analog;
    assign upper_read = upper_sync & ~upper_analog;

    // Peripheral overrides on the mixed port.
    wire logic [7:0] mixed_out_sel;
    wire logic [7:0] mixed_oe_sel;
    wire logic pulse_drives;
    assign pulse_drives = third_pulse_on_in;
    assign mixed_out_sel = {
        second_serial_on_in ? second_serial_transmit_in
                            : mixed_latch[asg_pkg::MIX_SER_TX],
        second_serial_on_in ? second_serial_sync_data_in
                            : mixed_latch[asg_pkg::MIX_SER_RX],
        pulse_drives ? third_pulse_output_in
                     : mixed_latch[asg_pkg::MIX_PULSE],
        mixed_latch[4:0]
    };
    assign mixed_oe_sel = {
        second_serial_on_in ? second_serial_transmit_oe_in
                            : ~mixed_dir[asg_pkg::MIX_SER_TX],
        second_serial_on_in ? second_serial_sync_data_oe_in
                            : ~mixed_dir[asg_pkg::MIX_SER_RX],
        pulse_drives | ~mixed_dir[asg_pkg::MIX_PULSE],
        ~mixed_dir[4:0] & ~mixed_analog[4:0]
    };

    // Pin drivers.
    assign port_one_drive_out.out = port_one_latch;
    assign port_one_drive_out.oe = ~port_one_dir & ~port_one_analog;
    assign mixed_drive_out.out = mixed_out_sel;
    assign mixed_drive_out.oe = mixed_oe_sel;
    assign upper_drive_out.out = upper_latch;
    assign upper_drive_out.oe = ~upper_dir & ~upper_analog;

    // Converter side.
    assign conv_cfg_out.clk_sel = conv_cfg[asg_pkg::CFG_CLK_HI:
                                           asg_pkg::CFG_CLK_LO];
    assign conv_cfg_out.result_format_select = conv_cfg[asg_pkg::CFG_FORMAT];
    assign conv_cfg_out.pcfg = conv_cfg[asg_pkg::CFG_PCFG_HI:0];
    assign vref_pos_out = ext_ref;
    assign vref_neg_out = ext_ref;
    wire logic [15:0] ref_chans;
    assign ref_chans = ext_ref ? ((16'h0001 << asg_pkg::CH_REF_POS)
                                  | (16'h0001 << asg_pkg::CH_REF_NEG))
                               : 16'h0000;
    assign analog_channel_out = chan_analog & ~ref_chans;

    // Peripheral inputs from the synchronised pins.
    assign third_capture_input_out = mixed_sync[asg_pkg::MIX_CAPTURE];
    assign second_serial_receive_out = mixed_sync[asg_pkg::MIX_SER_RX];
    assign second_serial_sync_clock_out =
        mixed_sync[asg_pkg::MIX_SER_TX];

    // Read multiplexer.
    wire logic [7:0] next_read_data;
    assign next_read_data =
        hit_port_one_dir ? port_one_dir :
        hit_port_one_pins ? port_one_read :
        hit_mixed_dir ? mixed_dir :
        hit_mixed_pins ? mixed_read :
        hit_conv_cfg ? (conv_cfg & 8'hEF) :
        hit_upper_dir ? upper_dir :
        hit_upper_pins ? upper_read :
        asg_pkg::READ_UNMAPPED;
    assign rdata_out = read_data;

    // Two-stage pin synchronisers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_one_meta <= 8'h00;
            mixed_meta <= 8'h00;
            upper_meta <= 8'h00;
            port_one_sync <= 8'h00;
            mixed_sync <= 8'h00;
            upper_sync <= 8'h00;
        end else begin
            port_one_meta <= port_one_pin_in;
            mixed_meta <= mixed_pin_in;
            upper_meta <= upper_pin_in;
            port_one_sync <= port_one_meta;
            mixed_sync <= mixed_meta;
            upper_sync <= upper_meta;
        end
    end

    // Direction registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_one_dir <= asg_pkg::RST_DIR;
            mixed_dir <= asg_pkg::RST_DIR;
            upper_dir <= asg_pkg::RST_DIR;
        end else if (req_in.wr) begin
            if (hit_port_one_dir) begin
                port_one_dir <= req_in.wdata;
            end
            if (hit_mixed_dir) begin
                mixed_dir <= req_in.wdata;
            end
            if (hit_upper_dir) begin
                upper_dir <= req_in.wdata;
            end
        end
    end

    // Output latches; a write never touches direction.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_one_latch <= asg_pkg::RST_LATCH;
            mixed_latch <= asg_pkg::RST_LATCH;
            upper_latch <= asg_pkg::RST_LATCH;
        end else if (req_in.wr) begin
            if (hit_port_one_pins) begin
                port_one_latch <= req_in.wdata;
            end
            if (hit_mixed_pins) begin
                mixed_latch <= req_in.wdata;
            end
            if (hit_upper_pins) begin
                upper_latch <= req_in.wdata;
            end
        end
    end

    // Converter configuration and read data.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_cfg <= asg_pkg::RST_CONV_CFG;
            read_data <= asg_pkg::READ_UNMAPPED;
        end else begin
            if (req_in.wr && hit_conv_cfg) begin
                conv_cfg <= req_in.wdata & 8'hEF;
            end
            if (req_in.rd) begin
                read_data <= next_read_data;
            end
        end
    end

    property p_dir_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        (req_in.wr && hit_mixed_dir) |=> mixed_dir == $past(req_in.wdata);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("Mixed direction did not take the write.");

    property p_oe_dir;
        @(posedge clk_in) disable iff (!rst_n_in)
        (req_in.wr && hit_port_one_dir &&
            conv_cfg[3:0] >= asg_pkg::PCFG_DIGITAL_MIN) |=>
            port_one_drive_out.oe == ~$past(req_in.wdata);
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("Port one driver does not follow direction.");

    property p_latch_only;
        @(posedge clk_in) disable iff (!rst_n_in)
        (req_in.wr && hit_upper_pins) |=>
            upper_latch == $past(req_in.wdata) && $stable(upper_dir);
    endproperty
    a_latch_only: assert property (p_latch_only)
        else $error("Upper port write did not load only the latch.");

    property p_read_pins;
        @(posedge clk_in) disable iff (!rst_n_in)
        (req_in.rd && hit_mixed_pins) |=>
            rdata_out == ($past(mixed_sync) & ~$past(mixed_analog));
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("Mixed port read did not return pin levels.");

    property p_pin_sync;
        @(posedge clk_in) disable iff (!rst_n_in)
        ##2 third_capture_input_out == $past(mixed_pin_in[4], 2);
    endproperty
    a_pin_sync: assert property (p_pin_sync)
        else $error("Capture input lags the pin by other than two.");

    property p_pulse_drive;
        @(posedge clk_in) disable iff (!rst_n_in)
        third_pulse_on_in |-> mixed_drive_out.oe[5] &&
            mixed_drive_out.out[5] == third_pulse_output_in;
    endproperty
    a_pulse_drive: assert property (p_pulse_drive)
        else $error("Pulse output not driven on its pin.");

    property p_analog_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        conv_cfg[3:0] < asg_pkg::PCFG_DIGITAL_MIN |->
            mixed_drive_out.oe[3:0] == 4'h0 &&
            upper_drive_out.oe[7:4] == 4'h0 &&
            port_one_drive_out.oe == 8'h00;
    endproperty
    a_analog_off: assert property (p_analog_off)
        else $error("Analog pin has its driver on.");

    property p_cfg_bit4;
        @(posedge clk_in) disable iff (!rst_n_in)
        (req_in.rd && hit_conv_cfg) |=> rdata_out[4] == 1'b0;
    endproperty
    a_cfg_bit4: assert property (p_cfg_bit4)
        else $error("Converter config bit 4 read as one.");

    property p_upper_low_digital;
        @(posedge clk_in) disable iff (!rst_n_in)
        upper_drive_out.oe[3:0] == ~upper_dir[3:0];
    endproperty
    a_upper_low_digital: assert property (p_upper_low_digital)
        else $error("Upper low nibble is not plain digital.");

    property p_upper_chan;
        @(posedge clk_in) disable iff (!rst_n_in)
        upper_drive_out.oe[7:4] != 4'h0 |->
            analog_channel_out[15:12] == 4'h0;
    endproperty
    a_upper_chan: assert property (p_upper_chan)
        else $error("Upper pin drives while its channel is analog.");

endmodule

`default_nettype wire
